/* File: logic/vwm_pkg.sv */
package vwm_pkg;
   // register byte offsets on the axi4-lite slave
   localparam logic [7:0] OFF_A_CTRL = 8'h00;
   localparam logic [7:0] OFF_A_BANK = 8'h04;
   localparam logic [7:0] OFF_B_CTRL = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0C;
   // window a control fields
   localparam int A_CPU_BIT = 3;
   localparam int A_FET_BIT = 2;
   localparam int A_SIZE_LSB = 0;
   localparam int A_BASE_LSB = 4;
   // window a bank fields
   localparam int A_GLB_BIT = 7;
   localparam int BANK_W = 7;
   // window b control fields
   localparam int B_CPU_BIT = 7;
   localparam int B_FET_BIT = 6;
   localparam int B_BANK_W = 5;
   // fixed window b geometry
   localparam logic [15:0] B_BASE = 16'h4000;
   localparam logic [15:0] B_SPAN = 16'h4000;
   localparam logic [15:0] PAGE = 16'h1000;
   localparam int VRAM_AW = 19;
   localparam logic [VRAM_AW-1:0] EXP_BASE = 19'h40000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic cpu_en;
      logic fet_en;
      logic [1:0] size;
      logic [3:0] base;
   } vwm_actrl_s;

   typedef struct packed {
      logic valid;
      logic fetcher;
      logic we;
      logic [15:0] addr;
      logic [7:0] wdata;
   } vwm_hreq_s;

   typedef enum logic [1:0] {VWM_IDLE, VWM_SERVE} vwm_state_e;
endpackage : vwm_pkg

/* File: logic/vwm_vram.sv */
module vwm_vram #(
   parameter int AW = 19
) (
   input wire logic aclk,
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   logic [7:0] mem [0:(1<<AW)-1];

   always_ff @(posedge aclk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule : vwm_vram

/* File: logic/vwm_axil.sv */
module vwm_axil (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic wr_en,
   output logic [7:0] wr_addr,
   output logic [7:0] wr_byte,
   output logic [7:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_ok,
   input wire logic wr_ok
);
   import vwm_pkg::*;
   logic aw_have_r;
   logic w_have_r;
   logic [7:0] aw_r;
   logic [7:0] wd_r;
   logic wlane_r;

   assign awready = !aw_have_r && !bvalid;
   assign wready = !w_have_r && !bvalid;
   assign arready = !rvalid;
   assign wr_en = aw_have_r && w_have_r && !bvalid;
   assign wr_addr = aw_r;
   assign wr_byte = wd_r;
   assign rd_addr = araddr;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_r <= 8'h00;
         wd_r <= 8'h00;
         wlane_r <= 1'b0;
      end else begin
         if (awvalid && awready) begin
            aw_have_r <= 1'b1;
            aw_r <= awaddr;
         end
         if (wvalid && wready) begin
            w_have_r <= 1'b1;
            wd_r <= wdata[7:0];
            wlane_r <= wstrb[0];
         end
         if (wr_en) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else if (wr_en) begin
         bvalid <= 1'b1;
         bresp <= (wr_ok && wlane_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata <= rd_ok ? rd_data : 32'h0000_0000;
         rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end
endmodule : vwm_axil

/* File: logic/vwm_top.sv */
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module vwm_top #(
   parameter bit EXPANSION = 1'b0
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire vwm_pkg::vwm_hreq_s host_req,
   input wire logic cas_inhibit_line,
   input wire logic host_decode_hit,
   input wire logic exp_sel,
   input wire logic [3:0] exp_bank,
   output logic external_select_line,
   output logic [7:0] host_rdata,
   output logic host_rvalid
);
   import vwm_pkg::*;

   //////////////////////////////////////////////////////////////////////////
   // registers
   vwm_actrl_s window_a_control_reg;
   logic window_global_enable;
   logic [BANK_W-1:0] a_bank_r;
   logic b_cpu_r;
   logic b_fet_r;
   logic [B_BANK_W-1:0] b_bank_r;
   logic [7:0] hit_count_r;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_byte;
   logic [7:0] rd_addr;
   logic [31:0] rd_data;
   logic rd_ok;
   logic wr_ok;

   function automatic logic reg_known(input logic [7:0] a);
      reg_known = (a == OFF_A_CTRL) || (a == OFF_A_BANK) || (a == OFF_B_CTRL) || (a == OFF_STATUS);
   endfunction : reg_known

   vwm_axil i_vwm_axil (
      .aclk(aclk),
      .aresetn(aresetn),
      .awaddr(s_axi_awaddr),
      .awvalid(s_axi_awvalid),
      .awready(s_axi_awready),
      .wdata(s_axi_wdata),
      .wstrb(s_axi_wstrb),
      .wvalid(s_axi_wvalid),
      .wready(s_axi_wready),
      .bresp(s_axi_bresp),
      .bvalid(s_axi_bvalid),
      .bready(s_axi_bready),
      .araddr(s_axi_araddr),
      .arvalid(s_axi_arvalid),
      .arready(s_axi_arready),
      .rdata(s_axi_rdata),
      .rresp(s_axi_rresp),
      .rvalid(s_axi_rvalid),
      .rready(s_axi_rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_byte(wr_byte),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_ok(rd_ok),
      .wr_ok(wr_ok)
   );

   assign wr_ok = reg_known(wr_addr) && (wr_addr != OFF_STATUS);
   // window b control is write only
   assign rd_ok = reg_known(rd_addr) && (rd_addr != OFF_B_CTRL);

   always_comb begin
      rd_data = 32'h0000_0000;
      case (rd_addr)
         OFF_A_CTRL: rd_data[7:0] = {window_a_control_reg.base, window_a_control_reg.cpu_en,
            window_a_control_reg.fet_en, window_a_control_reg.size};
         OFF_A_BANK: rd_data[7:0] = {window_global_enable, a_bank_r};
         OFF_STATUS: rd_data[7:0] = hit_count_r;
         default: rd_data = 32'h0000_0000;
      endcase
   end

   // base and size survive reset, only enables clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         window_a_control_reg.cpu_en <= 1'b0;
         window_a_control_reg.fet_en <= 1'b0;
      end else if (wr_en && wr_addr == OFF_A_CTRL) begin
         window_a_control_reg.cpu_en <= wr_byte[A_CPU_BIT];
         window_a_control_reg.fet_en <= wr_byte[A_FET_BIT];
         window_a_control_reg.base <= wr_byte[A_BASE_LSB +: 4];
         window_a_control_reg.size <= wr_byte[A_SIZE_LSB +: 2];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         window_global_enable <= 1'b0;
         a_bank_r <= '0;
      end else if (wr_en && wr_addr == OFF_A_BANK) begin
         window_global_enable <= wr_byte[A_GLB_BIT];
         a_bank_r <= wr_byte[BANK_W-1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         b_cpu_r <= 1'b0;
         b_fet_r <= 1'b0;
         b_bank_r <= '0;
      end else if (wr_en && wr_addr == OFF_B_CTRL) begin
         b_cpu_r <= wr_byte[B_CPU_BIT];
         b_fet_r <= wr_byte[B_FET_BIT];
         b_bank_r <= wr_byte[B_BANK_W-1:0];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // window decode
   logic [16:0] a_lo;
   logic [16:0] a_span;
   logic [16:0] a_off;
   logic a_party_en;
   logic b_party_en;
   logic a_hit;
   logic b_hit;
   logic exp_hit;
   logic claim;
   logic [VRAM_AW-1:0] vaddr;
   logic [7:0] vram_rdata;
   vwm_state_e state_r;

   assign a_lo = {1'b0, window_a_control_reg.base, 12'h000};
   assign a_span = 17'({1'b0, PAGE} << window_a_control_reg.size);
   assign a_off = {1'b0, host_req.addr} - a_lo;
   // separate cpu and fetcher enables let windows overlap per party
   assign a_party_en = window_global_enable
      && (host_req.fetcher ? window_a_control_reg.fet_en : window_a_control_reg.cpu_en);
   assign b_party_en = host_req.fetcher ? b_fet_r : b_cpu_r;
   // 16-bit host address cannot pass 0xffff, so the top truncates itself
   assign a_hit = a_party_en && ({1'b0, host_req.addr} >= a_lo) && (a_off < a_span);
   assign b_hit = b_party_en && (host_req.addr >= B_BASE) && (host_req.addr - B_BASE < B_SPAN);
   assign exp_hit = EXPANSION && exp_sel && !host_req.fetcher
      && (host_req.addr >= B_BASE) && (host_req.addr - B_BASE < B_SPAN);
   // rom selects and register decodes keep the bus
   assign claim = host_req.valid && !cas_inhibit_line && !host_decode_hit
      && (a_hit || b_hit || exp_hit);

   always_comb begin
      vaddr = '0;
      if (a_hit) begin
         // window a first where both match
         case (window_a_control_reg.size)
            2'h0: vaddr = VRAM_AW'({a_bank_r, a_off[11:0]});
            2'h1: vaddr = VRAM_AW'({a_bank_r, a_off[12:0]});
            2'h2: vaddr = VRAM_AW'({a_bank_r[BANK_W-2:0], a_off[13:0]});
            default: vaddr = VRAM_AW'({a_bank_r[BANK_W-3:0], a_off[14:0]});
         endcase
      end else if (b_hit) begin
         vaddr = {b_bank_r, host_req.addr[13:0]};
      end else if (exp_hit) begin
         vaddr = EXP_BASE | VRAM_AW'({exp_bank, host_req.addr[13:0]});
      end
   end

   vwm_vram #(.AW(VRAM_AW)) i_vwm_vram (
      .aclk(aclk),
      .we(claim && host_req.we),
      .addr(vaddr),
      .wdata(host_req.wdata),
      .rdata(vram_rdata)
   );

   assign external_select_line = claim;
   assign host_rdata = vram_rdata;

   // one cycle per byte, read data valid next edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= VWM_IDLE;
      end else begin
         case (state_r)
            VWM_IDLE: state_r <= (claim && !host_req.we) ? VWM_SERVE : VWM_IDLE;
            VWM_SERVE: state_r <= (claim && !host_req.we) ? VWM_SERVE : VWM_IDLE;
            default: state_r <= VWM_IDLE;
         endcase
      end
   end
   assign host_rvalid = (state_r == VWM_SERVE);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hit_count_r <= 8'h00;
      end else if (claim) begin
         hit_count_r <= hit_count_r + 8'h01;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // checks
   AST_ONE_CYCLE: assert property (@(posedge aclk) disable iff (!aresetn)
      claim && !host_req.we |=> host_rvalid) else $error("read not served next cycle");
   AST_SEL_HIT: assert property (@(posedge aclk) disable iff (!aresetn)
      external_select_line |-> (a_hit || b_hit || exp_hit)) else $error("select without hit");
   AST_CAS: assert property (@(posedge aclk) disable iff (!aresetn)
      cas_inhibit_line |-> !external_select_line) else $error("claimed rom access");
   AST_B_FIXED: assert property (@(posedge aclk) disable iff (!aresetn)
      b_hit |-> host_req.addr[15:14] == 2'h1) else $error("window b outside 0x4000");
   AST_A_PRIO: assert property (@(posedge aclk) disable iff (!aresetn)
      a_hit && b_hit && window_a_control_reg.size == 2'h0 |-> vaddr[VRAM_AW-1:12] == a_bank_r)
      else $error("window b beat a");
   AST_A_BASE: assert property (@(posedge aclk) disable iff (!aresetn)
      a_hit |-> host_req.addr[15:12] >= window_a_control_reg.base) else $error("hit below base");
   AST_RST_EN: assert property (@(posedge aclk)
      !aresetn |=> !window_a_control_reg.cpu_en && !window_a_control_reg.fet_en && !window_global_enable)
      else $error("reset left window a on");
   AST_DECODE: assert property (@(posedge aclk) disable iff (!aresetn)
      host_decode_hit |-> !external_select_line) else $error("vram beat register decode");
   AST_NOEXP: assert property (@(posedge aclk) disable iff (!aresetn)
      !EXPANSION |-> !exp_hit) else $error("expansion in plain build");
endmodule : vwm_top

/* File: verification/vwm_host_model.sv */
module vwm_host_model
   import vwm_pkg::*;
(
   input wire logic aclk,
   input wire logic ext_sel,
   input wire logic [7:0] rdata_in,
   input wire logic rvalid_in,
   output vwm_hreq_s req,
   output logic cas_inh,
   output logic dec_hit
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      req = '0;
      cas_inh = 1'b0;
      dec_hit = 1'b0;
   end

   // one byte cycle by cpu or fetcher, then bus released
   task automatic access(input logic f, input logic w, input logic [15:0] a, input logic [7:0] d,
      input logic ci, input logic dh, output logic hit, output logic [7:0] q, output logic ok);
      @(posedge aclk);
      req <= '{1'b1, f, w, a, d};
      cas_inh <= ci;
      dec_hit <= dh;
      @(negedge aclk);
      hit = ext_sel;
      @(posedge aclk);
      // released bus shows inverse of last value
      req <= '{1'b0, 1'b0, 1'b0, ~a, ~d};
      cas_inh <= 1'b0;
      dec_hit <= 1'b0;
      @(negedge aclk);
      q = rdata_in;
      ok = rvalid_in;
   endtask : access
endmodule : vwm_host_model

/* File: verification/test_vram_cpu_window_mapper.sv */
module test_vram_cpu_window_mapper;
   timeunit 1ns;
   timeprecision 1ps;
   import vwm_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic awvalid = 1'b0;
   logic awready;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic wvalid = 1'b0;
   logic wready;
   logic [1:0] bresp;
   logic bvalid;
   logic bready = 1'b0;
   logic [7:0] araddr = 8'h00;
   logic arvalid = 1'b0;
   logic arready;
   logic [31:0] rdata;
   logic [1:0] rresp;
   logic rvalid;
   logic rready = 1'b0;
   vwm_hreq_s host_req;
   logic cas_inh;
   logic dec_hit;
   logic ext_sel;
   logic [7:0] h_rdata;
   logic h_rvalid;
   int fails = 0;
   int num_checks = 0;

   always #50 aclk = ~aclk;

   vwm_top i_vwm_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .host_req(host_req),
      .cas_inhibit_line(cas_inh), .host_decode_hit(dec_hit), .exp_sel(1'b0), .exp_bank(4'h0),
      .external_select_line(ext_sel), .host_rdata(h_rdata), .host_rvalid(h_rvalid));

   vwm_host_model i_vwm_host_model (.aclk(aclk), .ext_sel(ext_sel), .rdata_in(h_rdata),
      .rvalid_in(h_rvalid), .req(host_req), .cas_inh(cas_inh), .dec_hit(dec_hit));

   ////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic rst();
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
   endtask : rst

   task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
      logic ah, wh;
      ah = 1'b0;
      wh = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= {24'h0, d};
      wstrb <= s;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!ah || !wh) begin
         @(negedge aclk);
         ah = ah | (awvalid & awready);
         wh = wh | (wvalid & wready);
         @(posedge aclk);
         if (ah) awvalid <= 1'b0;
         if (wh) wvalid <= 1'b0;
      end
      do begin
         @(negedge aclk);
      end while (bvalid !== 1'b1);
      chk({30'h0, bresp}, {30'h0, er});
      @(posedge aclk);
      bready <= 1'b0;
   endtask : axw

   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge aclk);
      end while (arready !== 1'b1);
      @(posedge aclk);
      arvalid <= 1'b0;
      do begin
         @(negedge aclk);
      end while (rvalid !== 1'b1);
      chk(rdata & m, e);
      chk({30'h0, rresp}, {30'h0, er});
      @(posedge aclk);
      rready <= 1'b0;
   endtask : rdc

   task automatic acc(input logic f, input logic w, input logic [15:0] a, input logic [7:0] d,
      input logic ci, input logic dh, input logic eh);
      logic hit, ok;
      logic [7:0] q;
      i_vwm_host_model.access(f, w, a, d, ci, dh, hit, q, ok);
      chk({31'h0, hit}, {31'h0, eh});
      if (!w && eh) begin
         chk({24'h0, q}, {24'h0, d});
         chk({31'h0, ok}, 32'h1);
      end
   endtask : acc

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      rdc(OFF_B_CTRL, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
      rdc(8'h10, 32'h0, 32'h0, RESP_SLVERR);
      axw(OFF_STATUS, 8'h00, 4'hF, RESP_SLVERR);
      axw(OFF_A_CTRL, 8'hFF, 4'hF, RESP_OKAY);
      rdc(OFF_A_CTRL, 32'hFFFFFFFF, 32'hFF, RESP_OKAY);
   endtask : t_regs

   task automatic t_win_b();
      axw(OFF_B_CTRL, 8'h83, 4'hF, RESP_OKAY);
      acc(1'b0, 1'b1, 16'h4000, 8'h5A, 1'b0, 1'b0, 1'b1);
      acc(1'b0, 1'b0, 16'h4000, 8'h5A, 1'b0, 1'b0, 1'b1);
      acc(1'b0, 1'b0, 16'h3FFF, 8'h00, 1'b0, 1'b0, 1'b0);
      acc(1'b0, 1'b0, 16'h8000, 8'h00, 1'b0, 1'b0, 1'b0);
      acc(1'b1, 1'b0, 16'h4000, 8'h00, 1'b0, 1'b0, 1'b0);
      axw(OFF_B_CTRL, 8'h43, 4'hF, RESP_OKAY);
      acc(1'b1, 1'b0, 16'h4000, 8'h5A, 1'b0, 1'b0, 1'b1);
      acc(1'b0, 1'b0, 16'h4000, 8'h00, 1'b0, 1'b0, 1'b0);
      acc(1'b1, 1'b0, 16'h4000, 8'h00, 1'b1, 1'b0, 1'b0);
      acc(1'b1, 1'b0, 16'h4000, 8'h00, 1'b0, 1'b1, 1'b0);
   endtask : t_win_b

   task automatic t_trunc();
      axw(OFF_B_CTRL, 8'h00, 4'hF, RESP_OKAY);
      axw(OFF_A_BANK, 8'h80, 4'hF, RESP_OKAY);
      axw(OFF_A_CTRL, 8'hFF, 4'hF, RESP_OKAY);
      acc(1'b1, 1'b0, 16'hFFFF, 8'h00, 1'b0, 1'b0, 1'b1);
      acc(1'b0, 1'b0, 16'hF000, 8'h00, 1'b0, 1'b0, 1'b1);
      acc(1'b0, 1'b0, 16'h0000, 8'h00, 1'b0, 1'b0, 1'b0);
      acc(1'b0, 1'b0, 16'hEFFF, 8'h00, 1'b0, 1'b0, 1'b0);
   endtask : t_trunc

   task automatic t_sizes();
      for (int s = 0; s < 4; s++) begin
         axw(OFF_A_CTRL, 8'h28 | 8'(s), 4'hF, RESP_OKAY);
         acc(1'b0, 1'b1, 16'h2000 + (16'h1000 << s) - 16'h1, 8'h3C, 1'b0, 1'b0, 1'b1);
         acc(1'b0, 1'b0, 16'h2000 + (16'h1000 << s), 8'h00, 1'b0, 1'b0, 1'b0);
      end
   endtask : t_sizes

   task automatic t_prio();
      axw(OFF_B_CTRL, 8'h80, 4'hF, RESP_OKAY);
      axw(OFF_A_CTRL, 8'h48, 4'hF, RESP_OKAY);
      axw(OFF_A_BANK, 8'h81, 4'hF, RESP_OKAY);
      acc(1'b0, 1'b1, 16'h4000, 8'h11, 1'b0, 1'b0, 1'b1);
      axw(OFF_A_BANK, 8'h01, 4'hF, RESP_OKAY);
      acc(1'b0, 1'b1, 16'h4000, 8'h22, 1'b0, 1'b0, 1'b1);
      axw(OFF_A_BANK, 8'h81, 4'hF, RESP_OKAY);
      acc(1'b0, 1'b0, 16'h4000, 8'h11, 1'b0, 1'b0, 1'b1);
      axw(OFF_A_CTRL, 8'h4C, 4'hF, RESP_OKAY);
      acc(1'b1, 1'b0, 16'h4000, 8'h11, 1'b0, 1'b0, 1'b1);
      axw(OFF_A_CTRL, 8'h48, 4'hF, RESP_OKAY);
      axw(OFF_B_CTRL, 8'h40, 4'hF, RESP_OKAY);
      acc(1'b1, 1'b0, 16'h4000, 8'h22, 1'b0, 1'b0, 1'b1);
      acc(1'b0, 1'b0, 16'h4000, 8'h11, 1'b0, 1'b0, 1'b1);
   endtask : t_prio

   task automatic t_reset();
      axw(OFF_A_CTRL, 8'h4E, 4'hF, RESP_OKAY);
      rst();
      rdc(OFF_A_CTRL, 32'hFFFFFFFF, 32'h42, RESP_OKAY);
      rdc(OFF_A_BANK, 32'h80, 32'h0, RESP_OKAY);
      rdc(OFF_STATUS, 32'hFF, 32'h0, RESP_OKAY);
      acc(1'b0, 1'b0, 16'h4000, 8'h00, 1'b0, 1'b0, 1'b0);
   endtask : t_reset

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst();
      t_regs();
      t_win_b();
      t_trunc();
      t_sizes();
      t_prio();
      t_reset();
      conclude();
   end

   // about a hundred times the expected run length
   initial begin
      #2000000;
      fails++;
      conclude();
   end
endmodule : test_vram_cpu_window_mapper
